// >>> ufc_pkg.sv
// Constants for the UART flow and feature control block.
// Assumes a 32-bit APB slave port and one UART clock domain.
package ufc_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_FEATURE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_ENHANCED_FEATURE = 8'h04;
    localparam logic [7:0] OFS_RESUME_FIRST = 8'h08;
    localparam logic [7:0] OFS_RESUME_SECOND = 8'h0C;
    localparam logic [7:0] OFS_STOP_FIRST = 8'h10;
    localparam logic [7:0] OFS_STOP_SECOND = 8'h14;
    localparam logic [7:0] OFS_TURN_DELAY = 8'h18;
    localparam logic [7:0] OFS_GATED_BITS = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int FC_HYST_LSB = 0;
    localparam int FC_IR_INV = 4;
    localparam int FC_HDX_EN = 5;
    localparam int FC_TABLE_LSB = 6;
    localparam int EF_RX_LSB = 0;
    localparam int EF_TX_LSB = 2;
    localparam int EF_ENH_EN = 4;
    localparam int EF_SPECIAL_EN = 5;
    localparam int TD_DELAY_LSB = 4;
    localparam int ST_SPECIAL = 0;
    localparam int ST_STOP_RX = 1;
    localparam int ST_PAUSED = 2;
    localparam int ST_STOP_SENT = 3;
    localparam int ST_RTS = 4;

    // ************************************************************
    // Reset values and fixed codes
    // ************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] TABLE_D = 2'h3;
    localparam logic [1:0] SWF_NONE = 2'h0;
    localparam logic [1:0] SWF_SECOND = 2'h1;
    localparam logic [1:0] SWF_FIRST = 2'h2;
    localparam logic [1:0] SWF_BOTH = 2'h3;
    localparam logic [1:0] STOP_WAIT_CHARS = 2'h2;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;

endpackage : ufc_pkg

// >>> ufc_flow_ctrl.sv
// Feature control, software flow control and half-duplex direction
// control for one UART channel, with an APB register port.
// Assumes the transmitter, receiver and FIFOs sit outside and give
// bit and character ticks, FIFO levels and received characters.
//
// Notes on behaviour
// - Hysteresis used only with trigger table D
// - Hysteresis select clears to zero on reset
// - Codes 0-7 give 0,4,6,8,8,16,24,32
// - Infrared receive polarity bit inverts input
// - Half-duplex off: interrupt on holding empty
// - Half-duplex: direction low after last stop
// - Half-duplex: interrupt on shift register empty
// - Tables A-C use next trigger levels
// - Upper flow bits choose characters sent
// - Dual mode sends/matches two consecutive characters; receive pair match only with transmit mode 00 or 11
// - Lower flow bits choose receive matching
// - Stop characters two character times after trigger
// - Resume below lower level or trigger-hysteresis
// - Enhanced bits writable only while enabled
// - Enhanced bits clear to zero on reset
// - Special character match stored, flag set
// - Mode 01 special match not stored, both flags
// - Direction change waits programmed bit times
`timescale 1ns/100ps
module ufc_flow_ctrl (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ir_rx_i,
    output logic ir_rx_o,
    input wire logic thr_empty_i,
    input wire logic tsr_empty_i,
    input wire logic tx_load_i,
    input wire logic bit_tick_i,
    input wire logic char_tick_i,
    input wire logic [6:0] rx_level_i,
    input wire logic [6:0] rx_trigger_i,
    input wire logic [6:0] rx_next_upper_i,
    input wire logic [6:0] rx_next_lower_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_char_i,
    output logic rx_store_o,
    output logic tx_int_o,
    output logic rts_out_o,
    output logic [6:0] flow_off_level_o,
    output logic [6:0] flow_on_level_o,
    output logic sw_char_valid_o,
    output logic [7:0] sw_char_o,
    input wire logic sw_char_ready_i,
    output logic tx_paused_o,
    output logic [10:0] enh_bits_o
);

    typedef enum logic [1:0] {SF_IDLE, SF_WAIT, SF_FIRST, SF_SECOND} ufc_sf_e;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [5:0] hyst_decode(input logic [3:0] code);
        logic [5:0] h;
        h = 6'h00;
        unique case (code)
            4'h0: h = 6'h00;
            4'h1: h = 6'h04;
            4'h2: h = 6'h06;
            4'h3: h = 6'h08;
            4'h4: h = 6'h08;
            4'h5: h = 6'h10;
            4'h6: h = 6'h18;
            4'h7: h = 6'h20;
            4'h8: h = 6'h28;
            4'h9: h = 6'h2C;
            4'hA: h = 6'h30;
            4'hB: h = 6'h34;
            4'hC: h = 6'h0C;
            4'hD: h = 6'h14;
            4'hE: h = 6'h1C;
            4'hF: h = 6'h24;
        endcase
        return h;
    endfunction

    function automatic logic sel_match(input logic [1:0] sel, input logic [7:0] c,
                                       input logic [7:0] first, input logic [7:0] second);
        return (sel[1] && c == first) || (sel[0] && c == second);
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] fctrl_ff;
    logic [7:0] efeat_ff;
    logic [7:0] res1_ff;
    logic [7:0] res2_ff;
    logic [7:0] stop1_ff;
    logic [7:0] stop2_ff;
    logic [3:0] turn_delay_ff;
    logic [10:0] enh_ff;
    logic special_flag_ff;
    logic stop_flag_ff;
    logic paused_ff;
    logic stop_sent_ff;
    logic [31:0] prdata_ff;
    logic rts_ff;
    logic [4:0] turn_cnt_ff;
    logic tx_int_ff;
    logic ir_ff;
    logic rx_store_ff;
    logic pend_stop_ff;
    logic pend_res_ff;
    ufc_sf_e sf_state_ff;
    ufc_sf_e nxt_sf_state;
    logic [1:0] wait_cnt_ff;
    logic send_stop_ff;
    logic [7:0] sw_char_ff;

    // ************************************************************
    // APB decode
    // ************************************************************
    wire setup = psel_i && !penable_i;
    wire wr_en = psel_i && penable_i && pwrite_i;
    wire sel_fc = paddr_i == ufc_pkg::OFS_FEATURE_CONTROL;
    wire sel_ef = paddr_i == ufc_pkg::OFS_ENHANCED_FEATURE;
    wire sel_r1 = paddr_i == ufc_pkg::OFS_RESUME_FIRST;
    wire sel_r2 = paddr_i == ufc_pkg::OFS_RESUME_SECOND;
    wire sel_s1 = paddr_i == ufc_pkg::OFS_STOP_FIRST;
    wire sel_s2 = paddr_i == ufc_pkg::OFS_STOP_SECOND;
    wire sel_td = paddr_i == ufc_pkg::OFS_TURN_DELAY;
    wire sel_gb = paddr_i == ufc_pkg::OFS_GATED_BITS;
    wire sel_st = paddr_i == ufc_pkg::OFS_STATUS;
    wire mapped = sel_fc | sel_ef | sel_r1 | sel_r2 | sel_s1 | sel_s2 | sel_td
                  | sel_gb | sel_st;
    wire [7:0] wbyte = pwdata_i[7:0];
    wire [7:0] status = {3'h0, rts_ff, stop_sent_ff, paused_ff, stop_flag_ff,
                         special_flag_ff};
    wire [7:0] rd_mux = sel_fc ? fctrl_ff :
                        sel_ef ? efeat_ff :
                        sel_r1 ? res1_ff :
                        sel_r2 ? res2_ff :
                        sel_s1 ? stop1_ff :
                        sel_s2 ? stop2_ff :
                        sel_gb ? enh_ff[7:0] :
                        sel_st ? status : 8'h00;
    // Turn delay is write-only and reads back as zero
    wire [31:0] rd_word = {21'h0, sel_gb ? enh_ff[10:8] : 3'h0, rd_mux};

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_ff;

    // ************************************************************
    // Field views
    // ************************************************************
    wire [3:0] hyst_sel = fctrl_ff[ufc_pkg::FC_HYST_LSB +: 4];
    wire hdx_en = fctrl_ff[ufc_pkg::FC_HDX_EN];
    wire table_d = fctrl_ff[ufc_pkg::FC_TABLE_LSB +: 2] == ufc_pkg::TABLE_D;
    wire [1:0] rx_mode = efeat_ff[ufc_pkg::EF_RX_LSB +: 2];
    wire [1:0] tx_mode = efeat_ff[ufc_pkg::EF_TX_LSB +: 2];
    wire enh_en = efeat_ff[ufc_pkg::EF_ENH_EN];
    wire special_en = efeat_ff[ufc_pkg::EF_SPECIAL_EN];

    // ************************************************************
    // Flow-control thresholds
    // ************************************************************
    wire [6:0] hyst = {1'b0, hyst_decode(hyst_sel)};
    wire [7:0] up_sum = {1'b0, rx_trigger_i} + {1'b0, hyst};
    wire [6:0] up_d = up_sum > {1'b0, ufc_pkg::FIFO_DEPTH} ? ufc_pkg::FIFO_DEPTH
                                                           : up_sum[6:0];
    wire [6:0] low_d = rx_trigger_i > hyst ? rx_trigger_i - hyst : 7'h00;
    assign flow_off_level_o = table_d ? up_d : rx_next_upper_i;
    assign flow_on_level_o = table_d ? low_d : rx_next_lower_i;

    // ************************************************************
    // Receive matching
    // ************************************************************
    wire seq_mode = rx_mode == ufc_pkg::SWF_BOTH
                    && (tx_mode == ufc_pkg::SWF_NONE || tx_mode == ufc_pkg::SWF_BOTH);
    wire [1:0] cmp_sel = rx_mode;
    wire single_stop = !seq_mode && sel_match(cmp_sel, rx_char_i, stop1_ff, stop2_ff);
    wire single_res = !seq_mode && sel_match(cmp_sel, rx_char_i, res1_ff, res2_ff);
    wire seq_stop = seq_mode && pend_stop_ff && rx_char_i == stop2_ff;
    wire seq_res = seq_mode && pend_res_ff && rx_char_i == res2_ff;
    wire got_stop = rx_valid_i && (single_stop || seq_stop);
    wire got_res = rx_valid_i && (single_res || seq_res);
    wire got_special = rx_valid_i && special_en && rx_char_i == stop2_ff;
    // Matched flow characters are consumed; a special match alone is kept
    wire keep = !(got_stop || got_res);

    // ************************************************************
    // Stop/resume transmit sequencer
    // ************************************************************
    wire tx_flow_on = tx_mode != ufc_pkg::SWF_NONE;
    wire want_stop = tx_flow_on && !stop_sent_ff && rx_level_i >= rx_trigger_i;
    wire want_res = tx_flow_on && stop_sent_ff && rx_level_i < flow_on_level_o;
    wire wait_done = char_tick_i && wait_cnt_ff == ufc_pkg::STOP_WAIT_CHARS - 2'h1;
    wire [7:0] char_a = send_stop_ff ? stop1_ff : res1_ff;
    wire [7:0] char_b = send_stop_ff ? stop2_ff : res2_ff;
    wire xfer = sw_char_valid_o && sw_char_ready_i;
    wire seq_end = xfer && (sf_state_ff == SF_SECOND || tx_mode == ufc_pkg::SWF_FIRST);

    always_comb begin
        nxt_sf_state = sf_state_ff;
        unique case (sf_state_ff)
            SF_IDLE: begin
                if (want_stop) begin
                    nxt_sf_state = SF_WAIT;
                end else if (want_res) begin
                    nxt_sf_state = tx_mode[1] ? SF_FIRST : SF_SECOND;
                end
            end
            SF_WAIT: begin
                if (!want_stop) begin
                    nxt_sf_state = SF_IDLE;
                end else if (wait_done) begin
                    nxt_sf_state = tx_mode[1] ? SF_FIRST : SF_SECOND;
                end
            end
            SF_FIRST: begin
                if (xfer) begin
                    nxt_sf_state = tx_mode[0] ? SF_SECOND : SF_IDLE;
                end
            end
            SF_SECOND: begin
                if (xfer) begin
                    nxt_sf_state = SF_IDLE;
                end
            end
        endcase
        if (!tx_flow_on) begin
            nxt_sf_state = SF_IDLE;
        end
    end

    assign sw_char_valid_o = sf_state_ff == SF_FIRST || sf_state_ff == SF_SECOND;
    assign sw_char_o = sw_char_ff;

    // ************************************************************
    // Half-duplex direction and transmit interrupt
    // ************************************************************
    wire tx_idle = thr_empty_i && tsr_empty_i;
    wire turn_done = turn_cnt_ff >= {1'b0, turn_delay_ff};
    assign rts_out_o = rts_ff;
    assign tx_int_o = tx_int_ff;
    assign ir_rx_o = ir_ff;
    assign rx_store_o = rx_store_ff;
    assign tx_paused_o = paused_ff;
    assign enh_bits_o = enh_ff;

    // ************************************************************
    // Clocked logic
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            fctrl_ff <= ufc_pkg::RST_BYTE;
            efeat_ff <= ufc_pkg::RST_BYTE;
            res1_ff <= ufc_pkg::RST_BYTE;
            res2_ff <= ufc_pkg::RST_BYTE;
            stop1_ff <= ufc_pkg::RST_BYTE;
            stop2_ff <= ufc_pkg::RST_BYTE;
            turn_delay_ff <= 4'h0;
            enh_ff <= 11'h000;
            prdata_ff <= 32'h0000_0000;
        end else begin
            if (setup) begin
                prdata_ff <= pwrite_i ? 32'h0000_0000 : rd_word;
            end
            if (wr_en && sel_fc) fctrl_ff <= wbyte;
            if (wr_en && sel_ef) efeat_ff <= wbyte;
            if (wr_en && sel_r1) res1_ff <= wbyte;
            if (wr_en && sel_r2) res2_ff <= wbyte;
            if (wr_en && sel_s1) stop1_ff <= wbyte;
            if (wr_en && sel_s2) stop2_ff <= wbyte;
            if (wr_en && sel_td) turn_delay_ff <= wbyte[ufc_pkg::TD_DELAY_LSB +: 4];
            if (wr_en && sel_gb && enh_en) enh_ff <= pwdata_i[10:0];
        end
    end

    // Status flags: a hardware set wins over a write-one clear
    wire clr_st = wr_en && sel_st;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            special_flag_ff <= 1'b0;
            stop_flag_ff <= 1'b0;
            paused_ff <= 1'b0;
            pend_stop_ff <= 1'b0;
            pend_res_ff <= 1'b0;
            rx_store_ff <= 1'b0;
        end else begin
            special_flag_ff <= got_special
                               || (special_flag_ff && !(clr_st && pwdata_i[ufc_pkg::ST_SPECIAL]));
            stop_flag_ff <= got_stop
                            || (stop_flag_ff && !(clr_st && pwdata_i[ufc_pkg::ST_STOP_RX]));
            if (got_stop) begin
                paused_ff <= 1'b1;
            end else if (got_res || rx_mode == ufc_pkg::SWF_NONE) begin
                paused_ff <= 1'b0;
            end
            if (rx_valid_i) begin
                pend_stop_ff <= rx_char_i == stop1_ff;
                pend_res_ff <= rx_char_i == res1_ff;
            end
            rx_store_ff <= rx_valid_i && keep;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sf_state_ff <= SF_IDLE;
            wait_cnt_ff <= 2'h0;
            send_stop_ff <= 1'b0;
            stop_sent_ff <= 1'b0;
            sw_char_ff <= 8'h00;
        end else begin
            sf_state_ff <= nxt_sf_state;
            if (sf_state_ff != SF_WAIT) begin
                wait_cnt_ff <= 2'h0;
            end else if (char_tick_i) begin
                wait_cnt_ff <= wait_cnt_ff + 2'h1;
            end
            if (sf_state_ff == SF_IDLE) begin
                send_stop_ff <= want_stop;
            end
            if (nxt_sf_state == SF_FIRST) begin
                sw_char_ff <= char_a;
            end else if (nxt_sf_state == SF_SECOND) begin
                sw_char_ff <= char_b;
            end
            if (!tx_flow_on) begin
                stop_sent_ff <= 1'b0;
            end else if (seq_end) begin
                stop_sent_ff <= send_stop_ff;
            end
        end
    end

    // Direction line idles high (transmitter side) until half-duplex is enabled
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rts_ff <= 1'b1;
            turn_cnt_ff <= 5'h00;
            tx_int_ff <= 1'b0;
            ir_ff <= 1'b0;
        end else begin
            ir_ff <= ir_rx_i ^ fctrl_ff[ufc_pkg::FC_IR_INV];
            tx_int_ff <= hdx_en ? tsr_empty_i : thr_empty_i;
            if (!hdx_en || tx_load_i || !tx_idle) begin
                turn_cnt_ff <= 5'h00;
            end else if (bit_tick_i && !turn_done) begin
                turn_cnt_ff <= turn_cnt_ff + 5'h01;
            end
            if (!hdx_en || tx_load_i) begin
                rts_ff <= 1'b1;
            end else if (tx_idle && turn_done && rts_ff) begin
                rts_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_HYST_TABLE_D: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !table_d |-> flow_off_level_o == rx_next_upper_i)
        else $error("Hysteresis applied outside table D");
    AST_RESET_CLEAR: assert property (@(posedge core_clk_i)
        !rst_n_i |=> fctrl_ff == 8'h00 && efeat_ff == 8'h00)
        else $error("Control not cleared by reset");
    AST_HYST_DECODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        table_d && hyst_sel == 4'h5 && rx_trigger_i >= 7'h10
        |-> rx_trigger_i - flow_on_level_o == 7'h10)
        else $error("Hysteresis code 5 not 16");
    AST_HYST_HIGH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        table_d && hyst_sel == 4'hC && rx_trigger_i >= 7'h0C
        |-> rx_trigger_i - flow_on_level_o == 7'h0C)
        else $error("Hysteresis code 12 not 12");
    AST_IR_POLARITY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rst_n_i |=> ir_rx_o == ($past(ir_rx_i) ^ $past(fctrl_ff[ufc_pkg::FC_IR_INV])))
        else $error("Infrared polarity wrong");
    AST_TX_INT_SRC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rst_n_i && !hdx_en && thr_empty_i |=> tx_int_o)
        else $error("Transmit interrupt missed on holding empty");
    AST_TX_INT_HDX: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        hdx_en && !tsr_empty_i |=> !tx_int_o)
        else $error("Transmit interrupt before shift empty");
    AST_RTS_LOAD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tx_load_i |=> rts_out_o)
        else $error("Direction not raised on load");
    AST_RTS_DELAY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(rts_out_o) |-> $past(turn_cnt_ff) >= {1'b0, turn_delay_ff})
        else $error("Direction dropped before delay");
    AST_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !enh_en |=> $stable(enh_bits_o))
        else $error("Enhanced bits changed while locked");
    AST_STOP_WAIT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        sf_state_ff == SF_IDLE && want_stop |=> !sw_char_valid_o [*2])
        else $error("Stop character sent without wait");
    AST_SPECIAL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        got_special |=> special_flag_ff)
        else $error("Special character flag not set");
    AST_MODE01: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rx_valid_i && rx_mode == ufc_pkg::SWF_SECOND && rx_char_i == stop2_ff
        |=> !rx_store_o && stop_flag_ff)
        else $error("Matched second stop stored");

endmodule // ufc_flow_ctrl

// >>> ufc_remote_model.sv
// Far-side transmitter model that takes software flow characters.
// Assumes one clock; ready is slow, high only every other cycle.
`timescale 1ns/100ps
module ufc_remote_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic sw_char_valid_i,
    input wire logic [7:0] sw_char_i,
    output logic sw_char_ready_o
);
    logic [7:0] got[$];
    always @(posedge core_clk_i) begin
        sw_char_ready_o <= rst_n_i && !sw_char_ready_o;
        if (rst_n_i && sw_char_valid_i && sw_char_ready_o) begin
            got.push_back(sw_char_i);
        end
    end
endmodule // ufc_remote_model

// >>> testbench.sv
// Self-checking bench for the flow and feature control block.
// Assumes APB with zero wait states and the remote model beside it.
`timescale 1ns/100ps
module testbench;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, ir_rx_i = 1'b1;
    logic thr_empty_i = 1'b1, tsr_empty_i = 1'b0, tx_load_i = 1'b0, bit_tick_i = 1'b0;
    logic char_tick_i = 1'b0, rx_valid_i = 1'b0, err;
    logic [7:0] paddr_i = 8'h00, rx_char_i = 8'h00, sw_char_o, ex[$];
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [6:0] rx_level_i = 7'h00, rx_trigger_i = 7'h3C;
    logic [6:0] rx_next_upper_i = 7'h3E, rx_next_lower_i = 7'h08;
    logic [6:0] flow_off_level_o, flow_on_level_o;
    logic pready_o, pslverr_o, ir_rx_o, rx_store_o, tx_int_o, rts_out_o;
    logic sw_char_valid_o, sw_char_ready_i, tx_paused_o;
    logic [10:0] enh_bits_o;
    int fails = 0, samples_checked = 0;
    int hyst[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
    always #50 core_clk_i = ~core_clk_i;
    ufc_flow_ctrl dut (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ir_rx_i, .ir_rx_o, .thr_empty_i,
        .tsr_empty_i, .tx_load_i, .bit_tick_i, .char_tick_i, .rx_level_i, .rx_trigger_i,
        .rx_next_upper_i, .rx_next_lower_i, .rx_valid_i, .rx_char_i, .rx_store_o,
        .tx_int_o, .rts_out_o, .flow_off_level_o, .flow_on_level_o, .sw_char_valid_o,
        .sw_char_o, .sw_char_ready_i, .tx_paused_o, .enh_bits_o);
    ufc_remote_model rm (.core_clk_i, .rst_n_i, .sw_char_valid_i(sw_char_valid_o),
        .sw_char_i(sw_char_o), .sw_char_ready_o(sw_char_ready_i));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task rx(input logic [7:0] c);
        @(posedge core_clk_i);
        rx_valid_i <= 1'b1;
        rx_char_i <= c;
        @(posedge core_clk_i);
        rx_valid_i <= 1'b0;
        @(negedge core_clk_i);
    endtask
    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        summarize;
    end
    initial begin
        cyc(5);
        rst_n_i <= 1'b1;
        apb(1'b0, ufc_pkg::OFS_FEATURE_CONTROL, 32'h0);
        chk("fctl reset", rd, 32'h0);
        apb(1'b0, ufc_pkg::OFS_GATED_BITS, 32'h0);
        chk("gated reset", rd, 32'h0);
        chk("rts reset", rts_out_o, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", err, 1'b1);
        $display("test reset done");
        chk("off table A", flow_off_level_o, rx_next_upper_i);
        apb(1'b1, ufc_pkg::OFS_FEATURE_CONTROL, 32'h45);
        chk("on table B", flow_on_level_o, rx_next_lower_i);
        for (int c = 1; c < 16; c++) begin
            apb(1'b1, ufc_pkg::OFS_FEATURE_CONTROL, 32'hC0 | c);
            cyc(1);
            chk("on table D", flow_on_level_o, 60 - hyst[c]);
        end
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, ufc_pkg::OFS_FEATURE_CONTROL, v << 4);
            cyc(2);
            chk("ir level", ir_rx_o, 1 - v);
        end
        chk("int holding", tx_int_o, 1'b1);
        apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h10);
        apb(1'b1, ufc_pkg::OFS_TURN_DELAY, 32'h30);
        apb(1'b1, ufc_pkg::OFS_FEATURE_CONTROL, 32'h20);
        cyc(2);
        chk("int shift busy", tx_int_o, 1'b0);
        tsr_empty_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk_i);
            bit_tick_i <= 1'b1;
            @(posedge core_clk_i);
            bit_tick_i <= 1'b0;
            if (i == 1)
                chk("rts in delay", rts_out_o, 1'b1);
        end
        cyc(2);
        chk("rts turned", rts_out_o, 1'b0);
        chk("int shift", tx_int_o, 1'b1);
        tx_load_i <= 1'b1;
        cyc(1);
        tx_load_i <= 1'b0;
        cyc(2);
        chk("rts load", rts_out_o, 1'b1);
        $display("test duplex done");
        apb(1'b1, ufc_pkg::OFS_FEATURE_CONTROL, 32'h0);
        apb(1'b1, ufc_pkg::OFS_RESUME_FIRST, 32'h11);
        apb(1'b1, ufc_pkg::OFS_RESUME_SECOND, 32'h91);
        apb(1'b1, ufc_pkg::OFS_STOP_FIRST, 32'h13);
        apb(1'b1, ufc_pkg::OFS_STOP_SECOND, 32'h93);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h10);
            apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h10 | (m << 2));
            rm.got.delete();
            rx_level_i <= 7'h3C;
            for (int t = 0; t < 2; t++) begin
                cyc(3);
                char_tick_i <= 1'b1;
                cyc(1);
                char_tick_i <= 1'b0;
                cyc(4);
                if (t == 0)
                    chk("early stop", rm.got.size(), 0);
            end
            cyc(12);
            rx_level_i <= 7'h00;
            cyc(12);
            ex = {};
            if (m[1]) ex.push_back(8'h13);
            if (m[0]) ex.push_back(8'h93);
            if (m[1]) ex.push_back(8'h11);
            if (m[0]) ex.push_back(8'h91);
            chk("sent count", rm.got.size(), ex.size());
            foreach (ex[i])
                chk("sent char", rm.got[i], ex[i]);
        end
        $display("test flow done");
        apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h10);
        apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h31);
        rx(8'h93);
        chk("store mode 01", rx_store_o, 1'b0);
        apb(1'b0, ufc_pkg::OFS_STATUS, 32'h0);
        chk("flags mode 01", rd[1:0], 2'h3);
        chk("paused", tx_paused_o, 1'b1);
        apb(1'b1, ufc_pkg::OFS_STATUS, 32'h3);
        apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h10);
        apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h32);
        rx(8'h93);
        chk("store mode 10", rx_store_o, 1'b1);
        apb(1'b0, ufc_pkg::OFS_STATUS, 32'h0);
        chk("special flag", rd[0], 1'b1);
        apb(1'b1, ufc_pkg::OFS_GATED_BITS, 32'h7FF);
        apb(1'b1, ufc_pkg::OFS_ENHANCED_FEATURE, 32'h0);
        apb(1'b1, ufc_pkg::OFS_GATED_BITS, 32'h0);
        apb(1'b0, ufc_pkg::OFS_GATED_BITS, 32'h0);
        chk("gated frozen", rd, 32'h7FF);
        chk("gated out", enh_bits_o, 11'h7FF);
        $display("test receive done");
        summarize;
    end
endmodule // testbench
